// [quad_wiper_register_control.sv]
// Top: serial slave, wiper and saved-setting registers for four channels
//
// What this block does
// R1: Every channel has its own 6-bit wiper position that alone picks its tap.
// R2: Every channel owns four 6-bit saved settings, sixteen in all.
// R3: After power-up the first saved setting of each channel is copied to its wiper with no bus command.
// R4: With the write-protect pin low saved-setting writes are refused while wiper changes still go through.
// R5: The block answers only when the received slave address matches its four address pins.
// R6: The data line is only pulled low or released, never driven high.
// R7: The master makes the serial clock and every bit moves on its edges.
// R8: Exactly one of the 64 taps per channel is connected, chosen by the wiper position.
// R9: The master can write both wiper positions and saved settings, but can read back only wiper positions.
// R10: Extra commands move a value between a wiper and any saved setting of the same channel.
// R11: A step command moves a wiper one position up or down instead of loading it.
// R12: The address pins form a 4-bit field, pin 0 as its lowest bit, compared with the address bits.
`timescale 1ns/1ps
module quad_wiper_register_control
	import wiper_pkg::*;
(
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst,
	input  wire logic                       i_scl,
	input  wire logic                       i_sda,
	output logic                            o_sda,
	output logic                            o_sda_oe,
	input  wire logic                       i_addr_pin_0,
	input  wire logic                       i_addr_pin_1,
	input  wire logic                       i_addr_pin_2,
	input  wire logic                       i_addr_pin_3,
	input  wire logic                       i_write_protect_n,
	output logic [CHANNELS*POS_W-1:0]       o_wiper_position,
	output logic [CHANNELS*TAPS-1:0]        o_tap
);
	wiper_if link ();

	typedef struct packed {
		bus_state_t       state;
		logic [3:0]       bit_cnt;
		logic [7:0]       shift;
		logic [7:0]       cmd;
		logic             rnw;
		logic             ack_ok;
		logic             sda_low;
		logic             loaded;
		logic [11:0]      addr_sh;
		logic [2:0]       wp_sh;
		logic [3:0]       addr_st;
		logic             wp_st;
		logic [CHANNELS*POS_W-1:0]              wiper;
		logic [CHANNELS*SAVED_PER_CH*POS_W-1:0] saved;
	} core_t;
	core_t r_reg;
	core_t r_next;

	logic [3:0] addr_pins;
	assign addr_pins = {i_addr_pin_3, i_addr_pin_2, i_addr_pin_1, i_addr_pin_0};  // [R12]

	line_sampler u_sampler (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_scl     (i_scl),
		.i_sda     (i_sda),
		.bus       (link.front)
	);

	tap_decoder u_taps (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.pos       (link.taps),
		.o_tap     (o_tap)
	);

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [POS_W-1:0] get_saved(input core_t r, input logic [1:0] ch, input logic [1:0] idx);
		logic [3:0] slot;
		slot = {ch, idx};
		return r.saved[int'(slot)*POS_W +: POS_W];
	endfunction

	logic [1:0] cmd_ch;
	logic [1:0] cmd_idx;
	logic [3:0] cmd_op;
	logic [3:0] slot_sel;
	logic [POS_W-1:0] cur_wiper;
	assign cmd_ch    = r_reg.cmd[CMD_CH_HI:CMD_CH_LO];
	assign cmd_idx   = r_reg.cmd[CMD_REG_HI:CMD_REG_LO];
	assign cmd_op    = r_reg.cmd[CMD_OP_HI:CMD_OP_LO];
	assign slot_sel  = {cmd_ch, cmd_idx};
	assign cur_wiper = r_reg.wiper[int'(cmd_ch)*POS_W +: POS_W];

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [7:0] shifted;
		shifted = {r_reg.shift[6:0], link.sda_in};
		r_next  = r_reg;
		r_next.addr_sh = {r_reg.addr_sh[7:0], addr_pins};
		r_next.wp_sh   = {r_reg.wp_sh[1:0], i_write_protect_n};
		// Straps pass three stages; a change counts once stages two and three agree
		if (r_reg.addr_sh[7:4] == r_reg.addr_sh[11:8]) begin
			r_next.addr_st = r_reg.addr_sh[11:8];  // [R12]
		end
		if (r_reg.wp_sh[1] == r_reg.wp_sh[2]) begin
			r_next.wp_st = r_reg.wp_sh[2];
		end

		// Power-up recall, once, before any bus traffic
		if (!r_reg.loaded) begin
			r_next.loaded = 1'b1;
			for (int c = 0; c < CHANNELS; c++) begin
				r_next.wiper[c*POS_W +: POS_W] = r_reg.saved[c*SAVED_PER_CH*POS_W +: POS_W];  // [R3]
			end
		end

		if (link.stop) begin
			r_next.state   = ST_IDLE;
			r_next.sda_low = 1'b0;
		end else if (link.start) begin
			r_next.state   = ST_ADDR;
			r_next.bit_cnt = '0;
			r_next.sda_low = 1'b0;
		end else if (link.scl_rise) begin  // [R7]
			case (r_reg.state)
				ST_ADDR, ST_CMD, ST_WDATA: begin
					r_next.shift   = shifted;
					r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
				end
				ST_RDATA: begin
					r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
				end
				ST_RACK: begin
					// Master NACK ends the read
					r_next.ack_ok = ~link.sda_in;
				end
				default: begin
				end
			endcase
		end else if (link.scl_fall) begin  // [R7]
			case (r_reg.state)
				ST_ADDR: begin
					if (r_reg.bit_cnt == 4'h8) begin
						if (r_reg.shift[7:5] == ADDR_PREFIX && r_reg.shift[4:1] == r_reg.addr_st) begin  // [R5] [R12]
							r_next.rnw     = r_reg.shift[0];
							r_next.sda_low = 1'b1;
							r_next.state   = ST_AACK;
						end else begin
							r_next.state = ST_WAIT;
						end
					end
				end
				ST_AACK: begin
					r_next.bit_cnt = '0;
					if (r_reg.rnw) begin
						// Read without command: return the last addressed wiper
						r_next.shift   = {2'h0, cur_wiper};
						r_next.state   = ST_RDATA;
						// Top bit of the returned byte is always zero
						r_next.sda_low = 1'b1;  // [R6]
					end else begin
						r_next.sda_low = 1'b0;
						r_next.state   = ST_CMD;
					end
				end
				ST_CMD: begin
					if (r_reg.bit_cnt == 4'h8) begin
						r_next.cmd     = r_reg.shift;
						r_next.sda_low = 1'b1;
						r_next.state   = ST_CACK;
					end
				end
				ST_CACK: begin
					r_next.sda_low = 1'b0;
					r_next.bit_cnt = '0;
					r_next.state   = ST_WAIT;
					case (cmd_op)
						OP_WRITE_WIPER, OP_WRITE_SAVED: r_next.state = ST_WDATA;  // [R9]
						OP_SAVED_TO_WP: begin
							r_next.wiper[int'(cmd_ch)*POS_W +: POS_W] = get_saved(r_reg, cmd_ch, cmd_idx);  // [R10]
						end
						OP_WP_TO_SAVED: begin
							if (r_reg.wp_st) begin  // [R4]
								r_next.saved[int'(slot_sel)*POS_W +: POS_W] = cur_wiper;  // [R10]
							end
						end
						OP_STEP: begin
							// Saturates at the ends rather than wrapping
							if (r_reg.cmd[STEP_UP_BIT]) begin
								if (cur_wiper != POS_MAX) begin
									r_next.wiper[int'(cmd_ch)*POS_W +: POS_W] = cur_wiper + 6'h01;  // [R11]
								end
							end else if (cur_wiper != POS_MIN) begin
								r_next.wiper[int'(cmd_ch)*POS_W +: POS_W] = cur_wiper - 6'h01;  // [R11]
							end
						end
						default: begin
						end
					endcase
				end
				ST_WDATA: begin
					if (r_reg.bit_cnt == 4'h8) begin
						r_next.sda_low = 1'b1;
						r_next.state   = ST_DACK;
						if (cmd_op == OP_WRITE_WIPER) begin
							r_next.wiper[int'(cmd_ch)*POS_W +: POS_W] = r_reg.shift[POS_W-1:0];  // [R1] [R9]
						end else if (r_reg.wp_st) begin  // [R4]
							r_next.saved[int'(slot_sel)*POS_W +: POS_W] = r_reg.shift[POS_W-1:0];  // [R2] [R9]
						end
					end
				end
				ST_DACK: begin
					r_next.sda_low = 1'b0;
					r_next.state   = ST_WAIT;
				end
				ST_RDATA: begin
					if (r_reg.bit_cnt == 4'h8) begin
						r_next.sda_low = 1'b0;
						r_next.state   = ST_RACK;
					end else begin
						r_next.sda_low = ~r_reg.shift[3'h7 - r_reg.bit_cnt[2:0]];  // [R6]
					end
				end
				ST_RACK: begin
					r_next.state = ST_WAIT;
					if (r_reg.ack_ok) begin
						r_next.bit_cnt = '0;
						r_next.state   = ST_RDATA;
						r_next.sda_low = ~r_reg.shift[7];
					end
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			r_reg       <= '0;
			r_reg.state <= ST_IDLE;
			r_reg.wp_st <= 1'b1;
			// Saved settings stand in for nonvolatile cells; reset models a fresh part
			r_reg.saved <= {CHANNELS*SAVED_PER_CH{SAVED_RESET}};
		end else begin
			r_reg <= r_next;
		end
	end

	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_tap
			assign link.tap_sel[c] = r_reg.wiper[c*POS_W +: POS_W];  // [R8]
		end
	endgenerate

	assign o_sda            = 1'b0;           // [R6]
	assign o_sda_oe         = r_reg.sda_low;  // [R6]
	assign o_wiper_position = r_reg.wiper;
endmodule

// [wiper_pkg.sv]
// Constants and types shared by the quad wiper control block
package wiper_pkg;
	localparam int CHANNELS      = 4;
	localparam int POS_W         = 6;
	localparam int SAVED_PER_CH  = 4;
	localparam int TAPS          = 64;
	localparam int ADDR_PINS     = 4;
	// Serial frame layout: 7-bit slave address + R/W, then command, then data
	localparam logic [2:0] ADDR_PREFIX  = 3'h5;
	localparam int         CMD_OP_HI    = 7;
	localparam int         CMD_OP_LO    = 4;
	localparam int         CMD_REG_HI   = 3;
	localparam int         CMD_REG_LO   = 2;
	localparam int         CMD_CH_HI    = 1;
	localparam int         CMD_CH_LO    = 0;
	// Command opcodes
	localparam logic [3:0] OP_READ_WIPER  = 4'h9;
	localparam logic [3:0] OP_WRITE_WIPER = 4'ha;
	localparam logic [3:0] OP_READ_SAVED  = 4'hb;
	localparam logic [3:0] OP_WRITE_SAVED = 4'hc;
	localparam logic [3:0] OP_SAVED_TO_WP = 4'hd;
	localparam logic [3:0] OP_WP_TO_SAVED = 4'he;
	localparam logic [3:0] OP_STEP        = 4'h2;
	// Step direction sits in the unused index field so it never aliases the channel
	localparam int         STEP_UP_BIT    = 2;
	localparam logic [POS_W-1:0] POS_MAX  = 6'h3f;
	localparam logic [POS_W-1:0] POS_MIN  = 6'h00;
	localparam logic [POS_W-1:0] SAVED_RESET = 6'h20;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_ADDR  = 4'h1,
		ST_AACK  = 4'h2,
		ST_CMD   = 4'h3,
		ST_CACK  = 4'h4,
		ST_WDATA = 4'h5,
		ST_DACK  = 4'h6,
		ST_RDATA = 4'h7,
		ST_RACK  = 4'h8,
		ST_WAIT  = 4'h9
	} bus_state_t;
endpackage

// [wiper_if.sv]
// Internal link between the serial front end and the register bank
`timescale 1ns/1ps
interface wiper_if;
	import wiper_pkg::*;
	logic             scl_rise;
	logic             scl_fall;
	logic             sda_in;
	logic             start;
	logic             stop;
	logic [POS_W-1:0] tap_sel [CHANNELS];
	modport front (output scl_rise, output scl_fall, output sda_in, output start, output stop);
	modport core  (input scl_rise, input scl_fall, input sda_in, input start, input stop);
	modport taps  (input tap_sel);
	modport bank  (output tap_sel);
endinterface

// [line_sampler.sv]
// Three-stage sampling of the bus pins with edge and condition detection
`timescale 1ns/1ps
module line_sampler
	import wiper_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	input  wire logic i_scl,
	input  wire logic i_sda,
	wiper_if.front    bus
);
	typedef struct packed {
		logic [2:0] scl_sh;
		logic [2:0] sda_sh;
		logic       scl_st;
		logic       sda_st;
		logic       rise;
		logic       fall;
		logic       start;
		logic       stop;
	} samp_t;
	samp_t s_reg;
	samp_t s_next;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_next        = s_reg;
		s_next.scl_sh = {s_reg.scl_sh[1:0], i_scl};
		s_next.sda_sh = {s_reg.sda_sh[1:0], i_sda};
		s_next.rise   = 1'b0;
		s_next.fall   = 1'b0;
		s_next.start  = 1'b0;
		s_next.stop   = 1'b0;
		// Stage 0 feeds stage 1 only; changes count when stages 1 and 2 agree
		if (s_reg.scl_sh[1] == s_reg.scl_sh[2] && s_reg.scl_sh[2] != s_reg.scl_st) begin
			s_next.scl_st = s_reg.scl_sh[2];
			s_next.rise   = s_reg.scl_sh[2];   // [R7]
			s_next.fall   = ~s_reg.scl_sh[2];  // [R7]
		end
		if (s_reg.sda_sh[1] == s_reg.sda_sh[2] && s_reg.sda_sh[2] != s_reg.sda_st) begin
			s_next.sda_st = s_reg.sda_sh[2];
			s_next.start  = s_reg.scl_st & ~s_reg.sda_sh[2];
			s_next.stop   = s_reg.scl_st & s_reg.sda_sh[2];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			s_reg <= '{scl_sh: 3'h7, sda_sh: 3'h7, scl_st: 1'b1, sda_st: 1'b1, default: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign bus.scl_rise = s_reg.rise;
	assign bus.scl_fall = s_reg.fall;
	assign bus.sda_in   = s_reg.sda_st;
	assign bus.start    = s_reg.start;
	assign bus.stop     = s_reg.stop;
endmodule

// [tap_decoder.sv]
// One-hot tap select per channel from the wiper positions
`timescale 1ns/1ps
module tap_decoder
	import wiper_pkg::*;
(
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst,
	wiper_if.taps                  pos,
	output logic [CHANNELS*TAPS-1:0] o_tap
);
	typedef struct packed {
		logic [CHANNELS*TAPS-1:0] tap;
	} dec_t;
	dec_t d_reg;
	dec_t d_next;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		d_next = '0;
		for (int c = 0; c < CHANNELS; c++) begin
			d_next.tap[c*TAPS + int'(pos.tap_sel[c])] = 1'b1;  // [R1] [R8]
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			d_reg <= '{tap: {CHANNELS{{(TAPS-1){1'b0}}, 1'b1}}};  // [R8]
		end else begin
			d_reg <= d_next;
		end
	end

	assign o_tap = d_reg.tap;
endmodule

// [qwrc_assertions.sv]
// Port-level property checker for the quad wiper control top
`timescale 1ns/1ps
module qwrc_assertions
	import wiper_pkg::*;
(
	input wire logic                      i_clk_sys,
	input wire logic                      i_rst,
	input wire logic                      i_scl,
	input wire logic                      i_sda,
	input wire logic                      o_sda,
	input wire logic                      o_sda_oe,
	input wire logic [CHANNELS*POS_W-1:0] o_wiper_position,
	input wire logic [CHANNELS*TAPS-1:0]  o_tap
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// Recall moves the wipers right after reset, so storage checks wait a while
	logic [3:0] since_rst_reg;
	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			since_rst_reg <= 4'h0;
		else if (since_rst_reg != 4'hf)
			since_rst_reg <= since_rst_reg + 4'h1;
	end
	function automatic logic taps_ok(logic [CHANNELS*TAPS-1:0] t, logic [CHANNELS*POS_W-1:0] w);
		taps_ok = 1'h1;
		for (int c = 0; c < CHANNELS; c++)
			taps_ok &= (t[c*TAPS +: TAPS] == (64'h1 << w[c*POS_W +: POS_W]));
	endfunction
	a_sda_low_only:
		assert property (o_sda == 1'h0) else $error("sda driven high");
	a_tap_onehot:
		assert property ($onehot(o_tap[63:0]) && $onehot(o_tap[127:64]) && $onehot(o_tap[191:128])
			&& $onehot(o_tap[255:192])) else $error("tap not one-hot");
	a_tap_match:
		assert property (taps_ok(o_tap, $past(o_wiper_position))) else $error("tap not from wiper");
	a_ack_stands:
		assert property (i_scl [*8] |-> $stable(o_sda_oe)) else $error("sda moved with clock high");
	a_start_free:
		assert property (i_scl && $past(i_scl) && $fell(i_sda) |-> !o_sda_oe) else $error("sda pulled at start");
	a_stop_quiet:
		assert property (i_scl && $rose(i_sda) |=> !o_sda_oe [*8]) else $error("sda pulled after stop");
	a_store_on_ack:
		assert property (since_rst_reg == 4'hf && $changed(o_wiper_position) |-> o_sda_oe || $past(o_sda_oe))
			else $error("wiper changed off ack");
	a_recall_saved:
		assert property ($fell(i_rst) |-> ##[1:3] o_wiper_position == {CHANNELS{SAVED_RESET}})
			else $error("no recall after reset");
endmodule
bind quad_wiper_register_control qwrc_assertions u_chk (
	.i_clk_sys       (i_clk_sys),
	.i_rst           (i_rst),
	.i_scl           (i_scl),
	.i_sda           (i_sda),
	.o_sda           (o_sda),
	.o_sda_oe        (o_sda_oe),
	.o_wiper_position(o_wiper_position),
	.o_tap           (o_tap)
);

// [i2c_master_model.sv]
// Two-wire bus master model: drives the clock and a data pull-down
`timescale 1ns/1ps
module i2c_master_model (
	output logic      o_scl,
	output logic      o_sda_drv,
	input  wire logic i_sda_line
);
	// Clock stands high between frames; data released to the pull-up
	initial begin
		o_scl = 1'h1;
		o_sda_drv = 1'h1;
	end
	task automatic begin_frame;
		o_sda_drv = 1'h0;
		#40;
		o_scl = 1'h0;
		#40;
	endtask
	task automatic end_frame;
		o_sda_drv = 1'h0;
		#40;
		o_scl = 1'h1;
		#40;
		o_sda_drv = 1'h1;
		#80;
	endtask
	// Data set mid low phase, sampled at end of high phase
	task automatic bit_io(input logic b, output logic r);
		o_sda_drv = b;
		#40;
		o_scl = 1'h1;
		#80;
		r = i_sda_line;
		o_scl = 1'h0;
		#40;
	endtask
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(mack, r);
		ack = ~r;
	endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the quad wiper control block
`timescale 1ns/1ps
module tb_top;
	import wiper_pkg::*;
	localparam logic [3:0] PINS = 4'h3;
	localparam logic [7:0] AD_W = {ADDR_PREFIX, PINS, 1'h0};
	logic                      clk_sys = 1'h0;
	logic                      rst = 1'h1;
	logic                      wp_n = 1'h1;
	logic                      scl;
	logic                      sda_drv;
	logic                      sda_oe;
	logic [CHANNELS*POS_W-1:0] wiper;
	logic [CHANNELS*TAPS-1:0]  tap;
	int                        err_total = 0;
	int                        num_checks = 0;
	wire logic                 sda_line = sda_drv & ~sda_oe;
	always #2.5 clk_sys = ~clk_sys;
	i2c_master_model m (.o_scl(scl), .o_sda_drv(sda_drv), .i_sda_line(sda_line));
	quad_wiper_register_control dut (
		.i_clk_sys        (clk_sys),
		.i_rst            (rst),
		.i_scl            (scl),
		.i_sda            (sda_line),
		.o_sda            (),
		.o_sda_oe         (sda_oe),
		.i_addr_pin_0     (PINS[0]),
		.i_addr_pin_1     (PINS[1]),
		.i_addr_pin_2     (PINS[2]),
		.i_addr_pin_3     (PINS[3]),
		.i_write_protect_n(wp_n),
		.o_wiper_position (wiper),
		.o_tap            (tap)
	);
	////////////////////////////////////////
	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_ack(input logic got, input logic exp);
		chk_val({63'h0, got}, {63'h0, exp});
	endtask
	task automatic chk_pos(input int c, input logic [5:0] exp);
		chk_val(64'(wiper[c*POS_W +: POS_W]), 64'(exp));
		chk_val(tap[c*TAPS +: TAPS], 64'h1 << exp);
	endtask
	task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input bit has_dat);
		logic [7:0] q;
		logic       a;
		m.begin_frame();
		m.xfer(AD_W, 1'h1, q, a);
		chk_ack(a, 1'h1);
		m.xfer(cmd, 1'h1, q, a);
		chk_ack(a, 1'h1);
		if (has_dat) begin
			m.xfer(dat, 1'h1, q, a);
			chk_ack(a, 1'h1);
		end
		m.end_frame();
	endtask
	task automatic rd_check(input logic [5:0] exp);
		logic [7:0] q;
		logic       a;
		m.begin_frame();
		m.xfer(AD_W | 8'h1, 1'h1, q, a);
		chk_ack(a, 1'h1);
		m.xfer(8'hff, 1'h1, q, a);
		chk_val(64'(q[5:0]), 64'(exp));
		m.end_frame();
	endtask
	task automatic t_recall;
		for (int c = 0; c < CHANNELS; c++) begin
			chk_pos(c, SAVED_RESET);
		end
		$display("recall test done");
	endtask
	task automatic t_wiper_rw;
		frame({OP_WRITE_WIPER, 4'h2}, 8'hff, 1'b1);
		chk_pos(2, POS_MAX);
		frame({OP_WRITE_WIPER, 4'h0}, 8'h15, 1'b1);
		chk_pos(0, 6'h15);
		chk_pos(1, SAVED_RESET);
		frame({OP_READ_WIPER, 4'h0}, 8'h00, 1'b0);
		rd_check(6'h15);
		$display("wiper rw test done");
	endtask
	task automatic t_addr_miss;
		logic [7:0] q;
		logic       a;
		m.begin_frame();
		m.xfer({ADDR_PREFIX, 4'hc, 1'h0}, 1'h1, q, a);
		chk_ack(a, 1'h0);
		m.xfer({OP_WRITE_WIPER, 4'h1}, 1'h1, q, a);
		m.xfer(8'h05, 1'h1, q, a);
		m.end_frame();
		chk_pos(1, SAVED_RESET);
		$display("address test done");
	endtask
	task automatic t_saved;
		frame({OP_WRITE_SAVED, 4'h5}, 8'h0a, 1'b1);
		frame({OP_SAVED_TO_WP, 4'h5}, 8'h00, 1'b0);
		chk_pos(1, 6'h0a);
		frame({OP_WP_TO_SAVED, 4'he}, 8'h00, 1'b0);
		frame({OP_WRITE_WIPER, 4'h2}, 8'h00, 1'b1);
		frame({OP_SAVED_TO_WP, 4'he}, 8'h00, 1'b0);
		chk_pos(2, POS_MAX);
		$display("saved test done");
	endtask
	task automatic t_protect;
		wp_n = 1'h0;
		frame({OP_WRITE_SAVED, 4'hb}, 8'h11, 1'b1);
		frame({OP_WRITE_WIPER, 4'h3}, 8'h07, 1'b1);
		chk_pos(3, 6'h07);
		frame({OP_SAVED_TO_WP, 4'hb}, 8'h00, 1'b0);
		chk_pos(3, SAVED_RESET);
		wp_n = 1'h1;
		$display("protect test done");
	endtask
	task automatic t_step;
		frame({OP_WRITE_WIPER, 4'h0}, 8'h3e, 1'b1);
		frame({OP_STEP, 4'h4}, 8'h00, 1'b0);
		chk_pos(0, POS_MAX);
		frame({OP_STEP, 4'h4}, 8'h00, 1'b0);
		chk_pos(0, POS_MAX);
		frame({OP_STEP, 4'h0}, 8'h00, 1'b0);
		chk_pos(0, 6'h3e);
		$display("step test done");
	endtask
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'h0;
		repeat (12) @(negedge clk_sys);
		t_recall();
		t_wiper_rw();
		t_addr_miss();
		t_saved();
		t_protect();
		t_step();
		report_and_stop();
	end
	// Cuts a hung run short
	initial begin
		#400000;
		err_total++;
		report_and_stop();
	end
endmodule
